// file: misr_pkg.sv
// Constants for the first interrupt status register of the monitor
package misr_pkg;
	localparam logic [7:0] MISR_STATUS_ONE_ADDR  = 8'h41;
	localparam logic [7:0] MISR_VOLT_ENABLE_ADDR = 8'h7e;
	localparam logic [7:0] MISR_TEMP_ENABLE_ADDR = 8'h82;
	localparam logic [7:0] MISR_STATUS_RESET     = 8'h00;
	localparam int         MISR_NUM_CHANNELS     = 7;
	localparam int         MISR_NUM_VOLT         = 4;
	localparam int         MISR_SUMMARY_BIT      = 7;
	localparam int         MISR_READING_W        = 8;
	localparam int         MISR_TEMP_EN_LSB      = 4;
endpackage : misr_pkg

// file: misr_limit_check.sv
// Out-of-limit comparator for one monitored reading
`timescale 1ns/10ps
module misr_limit_check
	import misr_pkg::*;
(
	input  wire logic [MISR_READING_W-1:0] reading_i,
	input  wire logic [MISR_READING_W-1:0] low_limit_i,
	input  wire logic [MISR_READING_W-1:0] high_limit_i,
	output logic                           violate_o
);
	// At or below low, strictly above high
	assign violate_o = (reading_i <= low_limit_i) || (reading_i > high_limit_i);
endmodule : misr_limit_check

// file: misr_summary_sync.sv
// Two-stage synchroniser for the second-register summary level
`timescale 1ns/10ps
module misr_summary_sync
	import misr_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic level_i,
	output logic      level_o
);
	logic meta_ff;
	logic sync_ff;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= level_i;
			sync_ff <= meta_ff;
		end
	end

	assign level_o = sync_ff;
endmodule : misr_summary_sync

// file: misr_status_one.sv
// Sticky status register one with clear-on-read and summary bit
`timescale 1ns/10ps
// Function
// [R01] Host read clears to zero bits whose event is gone; reset value 00h (here a read clears all bits 0-6, or none while any set one is still active)
// [R02] Host writes to the status register change nothing
// [R03] Bit sets when enabled and its measurement violates limits
// [R04] Set bits stay until host read or enable cleared
// [R05] Group and global interrupt enables do not affect status bits
// [R06] Bit 7 set whenever second status register has any bit set
// [R07] Bit 7 clears itself when second register holds nothing
// [R08] Host polls this register, reads the second only on bit 7
// [R09] Disabled bit never goes from 0 to 1
// [R10] Disabled set bit clears at next update of its reading
// [R11] Readings update only while monitoring runs; disabled bit waits
// [R12] Bits 0-3 flag 2.5V, core, main, 5V; low inclusive, high strict
// [R13] Bits 4-6 flag diode one, internal, diode two; same compare
// [R14] Temperature enables from register 82h, voltage enables from 7Eh
// [R15] No measurement and no setting while monitoring is stopped
// [R16] Clear applies after read data captured; same-cycle event not lost
module misr_status_one
	import misr_pkg::*;
(
	input  wire logic                           clk_i,
	input  wire logic                           reset_n_i,
	input  wire logic                           reg_rd_i,
	input  wire logic                           reg_wr_i,
	input  wire logic [7:0]                     reg_addr_i,
	input  wire logic [7:0]                     reg_wdata_i,
	input  wire logic                           start_monitor_i,
	input  wire logic [MISR_NUM_CHANNELS-1:0]   reading_update_i,
	input  wire logic [MISR_READING_W-1:0]      two_half_volt_rd_i,
	input  wire logic [MISR_READING_W-1:0]      core_volt_rd_i,
	input  wire logic [MISR_READING_W-1:0]      main_volt_rd_i,
	input  wire logic [MISR_READING_W-1:0]      five_volt_rd_i,
	input  wire logic [MISR_READING_W-1:0]      remote_one_rd_i,
	input  wire logic [MISR_READING_W-1:0]      internal_rd_i,
	input  wire logic [MISR_READING_W-1:0]      remote_two_rd_i,
	input  wire logic [MISR_READING_W-1:0]      two_half_volt_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      two_half_volt_limit_hi_i,
	input  wire logic [MISR_READING_W-1:0]      core_volt_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      core_volt_limit_hi_i,
	input  wire logic [MISR_READING_W-1:0]      main_volt_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      main_volt_limit_hi_i,
	input  wire logic [MISR_READING_W-1:0]      five_volt_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      five_volt_limit_hi_i,
	input  wire logic [MISR_READING_W-1:0]      remote_diode_one_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      remote_diode_one_limit_hi_i,
	input  wire logic [MISR_READING_W-1:0]      internal_temp_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      internal_temp_limit_hi_i,
	input  wire logic [MISR_READING_W-1:0]      remote_diode_two_limit_lo_i,
	input  wire logic [MISR_READING_W-1:0]      remote_diode_two_limit_hi_i,
	input  wire logic [7:0]                     volt_enable_i,
	input  wire logic [7:0]                     temp_enable_i,
	input  wire logic                           second_status_summary_i,
	output logic [7:0]                          reg_rdata_o,
	output logic [7:0]                          status_o
);
	logic [MISR_NUM_CHANNELS-1:0] status_ff;
	logic [MISR_NUM_CHANNELS-1:0] nxt_status;
	logic [7:0]                   rdata_ff;
	logic [7:0]                   nxt_rdata;
	logic [7:0]                   status_out_ff;
	logic                         summary_sync;
	logic [MISR_NUM_CHANNELS-1:0] enable;
	logic [MISR_NUM_CHANNELS-1:0] violate;
	logic [MISR_NUM_CHANNELS-1:0] event_set;
	logic [MISR_NUM_CHANNELS-1:0] active;
	logic [MISR_NUM_CHANNELS-1:0] disable_clr;
	logic [MISR_READING_W-1:0]    rd_vec [MISR_NUM_CHANNELS];
	logic [MISR_READING_W-1:0]    lo_vec [MISR_NUM_CHANNELS];
	logic [MISR_READING_W-1:0]    hi_vec [MISR_NUM_CHANNELS];
	logic                         status_read;
	logic                         any_active;

	// Channel order follows the bit order of the register
	assign rd_vec[0] = two_half_volt_rd_i;
	assign rd_vec[1] = core_volt_rd_i;
	assign rd_vec[2] = main_volt_rd_i;
	assign rd_vec[3] = five_volt_rd_i;
	assign rd_vec[4] = remote_one_rd_i;
	assign rd_vec[5] = internal_rd_i;
	assign rd_vec[6] = remote_two_rd_i;
	assign lo_vec[0] = two_half_volt_limit_lo_i;
	assign lo_vec[1] = core_volt_limit_lo_i;
	assign lo_vec[2] = main_volt_limit_lo_i;
	assign lo_vec[3] = five_volt_limit_lo_i;
	assign lo_vec[4] = remote_diode_one_limit_lo_i;
	assign lo_vec[5] = internal_temp_limit_lo_i;
	assign lo_vec[6] = remote_diode_two_limit_lo_i;
	assign hi_vec[0] = two_half_volt_limit_hi_i;
	assign hi_vec[1] = core_volt_limit_hi_i;
	assign hi_vec[2] = main_volt_limit_hi_i;
	assign hi_vec[3] = five_volt_limit_hi_i;
	assign hi_vec[4] = remote_diode_one_limit_hi_i;
	assign hi_vec[5] = internal_temp_limit_hi_i;
	assign hi_vec[6] = remote_diode_two_limit_hi_i;

	// Individual enables only; group and global enables never reach here
	assign enable = {temp_enable_i[MISR_TEMP_EN_LSB-1 -:
	                 (MISR_NUM_CHANNELS-MISR_NUM_VOLT)],
	                 volt_enable_i[MISR_NUM_VOLT-1:0]}; // [R14] [R05]

	genvar g;
	generate
		for (g = 0; g < MISR_NUM_CHANNELS; g++) begin : g_chan
			misr_limit_check u_chk (
				.reading_i    (rd_vec[g]),
				.low_limit_i  (lo_vec[g]),
				.high_limit_i (hi_vec[g]),
				.violate_o    (violate[g])
			); // [R12] [R13]
			// Evaluated only on a fresh reading while monitoring runs
			assign event_set[g] = start_monitor_i && reading_update_i[g]
			                      && enable[g] && violate[g]; // [R03] [R09] [R15]
			// Condition still present keeps the bit through a read
			assign active[g] = enable[g] && violate[g]
			                   && start_monitor_i;
			assign disable_clr[g] = start_monitor_i && reading_update_i[g]
			                        && !enable[g]; // [R10] [R11]
		end
	endgenerate

	misr_summary_sync u_sum (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.level_i   (second_status_summary_i),
		.level_o   (summary_sync)
	);

	assign status_read = reg_rd_i && (reg_addr_i == MISR_STATUS_ONE_ADDR);
	assign any_active = |(active & status_ff);

	// Writes are not decoded at all, so the register cannot be written
	// [R02]
	always_comb begin
		nxt_status = status_ff;
		if (status_read && !any_active) begin
			nxt_status = '0; // [R01]
		end
		nxt_status = nxt_status & ~disable_clr; // [R10] [R04]
		nxt_status = nxt_status | event_set; // [R16] [R04]
	end

	// Summary tracks the second register, never sticky here
	// Host gets the byte status_o showed, so bit 7 cannot skew
	assign nxt_rdata = status_read ? status_out_ff : rdata_ff;
	// [R06] [R07]

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_ff     <= MISR_STATUS_RESET[MISR_NUM_CHANNELS-1:0];
			rdata_ff      <= MISR_STATUS_RESET;
			status_out_ff <= MISR_STATUS_RESET;
		end else begin
			status_ff     <= nxt_status;
			rdata_ff      <= nxt_rdata; // [R16]
			status_out_ff <= {summary_sync, nxt_status};
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign status_o    = status_out_ff;
endmodule : misr_status_one

// file: misr_status_one_chk.sv
// Assertions for status register one
`timescale 1ns/10ps
module misr_status_one_chk
	import misr_pkg::*;
(
	input wire logic                         clk_i,
	input wire logic                         reset_n_i,
	input wire logic                         reg_rd_i,
	input wire logic [7:0]                   reg_addr_i,
	input wire logic                         start_monitor_i,
	input wire logic [MISR_NUM_CHANNELS-1:0] reading_update_i,
	input wire logic [7:0]                   volt_enable_i,
	input wire logic [7:0]                   temp_enable_i,
	input wire logic                         second_status_summary_i,
	input wire logic [7:0]                   reg_rdata_o,
	input wire logic [7:0]                   status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire logic rd41 = reg_rd_i && reg_addr_i == MISR_STATUS_ONE_ADDR;
	// Sync delay is two flops plus the status flop
	sequence sum_on; second_status_summary_i[*3]; endsequence
	sequence sum_off; (!second_status_summary_i)[*3]; endsequence
	rd_data_a: assert property (rd41 |=> reg_rdata_o == $past(status_o))
		else $error("Read data not pre-clear");
	rd_hold_a: assert property (!rd41 |=> $stable(reg_rdata_o))
		else $error("Read data moved");
	rd_clr_a: assert property (rd41 && !start_monitor_i |=>
		status_o[6:0] == 7'h00) else $error("Read did not clear");
	no_upd_a: assert property (reading_update_i == 7'h00 && !rd41 |=>
		$stable(status_o[6:0])) else $error("Status moved idle");
	stop_a: assert property (!start_monitor_i |=>
		(status_o[6:0] & ~$past(status_o[6:0])) == 7'h00)
		else $error("Set while stopped");
	v_dis_a: assert property (1'b1 |=> (status_o[3:0] &
		~$past(status_o[3:0]) & ~$past(volt_enable_i[3:0])) == 4'h0)
		else $error("Disabled volt bit set");
	t_dis_a: assert property (1'b1 |=> (status_o[6:4] &
		~$past(status_o[6:4]) & ~$past(temp_enable_i[3:1])) == 3'h0)
		else $error("Disabled temp bit set");
	sum_on_a: assert property (sum_on |=> status_o[MISR_SUMMARY_BIT])
		else $error("Summary not set");
	sum_off_a: assert property (sum_off |=> !status_o[MISR_SUMMARY_BIT])
		else $error("Summary not cleared");
endmodule : misr_status_one_chk
bind misr_status_one misr_status_one_chk u_chk (.clk_i, .reset_n_i, .reg_rd_i,
	.reg_addr_i, .start_monitor_i, .reading_update_i, .volt_enable_i,
	.temp_enable_i, .second_status_summary_i, .reg_rdata_o, .status_o);

// file: misr_host_model.sv
// Host model issuing single register cycles
`timescale 1ns/10ps
module misr_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic            reg_rd_o    = 1'b0,
	output logic            reg_wr_o    = 1'b0,
	output logic [7:0]      reg_addr_o  = 8'h00,
	output logic [7:0]      reg_wdata_o = 8'h00
);
	// Polls register one only; second register left to bit 7
	task automatic cyc(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		@(posedge clk_i);
		reg_rd_o <= !w;
		reg_wr_o <= w;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
		#1 q = reg_rdata_i;
	endtask : cyc
endmodule : misr_host_model

// file: tb.sv
// Self-checking testbench for status register one
`timescale 1ns/10ps
module tb;
	logic       clk_i = 1'b0, reset_n_i = 1'b0, start_monitor_i = 1'b0;
	logic       second_status_summary_i = 1'b0;
	logic [6:0] reading_update_i = 7'h00;
	logic [7:0] volt_enable_i = 8'h00, temp_enable_i = 8'h00, q;
	logic [7:0] rv [7], lo [7], hi [7];
	wire logic  reg_rd_i, reg_wr_i;
	wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, status_o;
	int         err_total = 0, num_checks = 0;
	localparam logic [7:0] A = misr_pkg::MISR_STATUS_ONE_ADDR;
	always #5 clk_i = ~clk_i;
	misr_status_one u_dut (.clk_i, .reset_n_i, .reg_rd_i, .reg_wr_i,
		.reg_addr_i, .reg_wdata_i, .start_monitor_i, .reading_update_i,
		.volt_enable_i, .temp_enable_i, .second_status_summary_i,
		.reg_rdata_o, .status_o, .two_half_volt_rd_i(rv[0]),
		.core_volt_rd_i(rv[1]), .main_volt_rd_i(rv[2]), .five_volt_rd_i(rv[3]),
		.remote_one_rd_i(rv[4]), .internal_rd_i(rv[5]), .remote_two_rd_i(rv[6]),
		.two_half_volt_limit_lo_i(lo[0]), .two_half_volt_limit_hi_i(hi[0]),
		.core_volt_limit_lo_i(lo[1]), .core_volt_limit_hi_i(hi[1]),
		.main_volt_limit_lo_i(lo[2]), .main_volt_limit_hi_i(hi[2]),
		.five_volt_limit_lo_i(lo[3]), .five_volt_limit_hi_i(hi[3]),
		.remote_diode_one_limit_lo_i(lo[4]), .remote_diode_one_limit_hi_i(hi[4]),
		.internal_temp_limit_lo_i(lo[5]), .internal_temp_limit_hi_i(hi[5]),
		.remote_diode_two_limit_lo_i(lo[6]), .remote_diode_two_limit_hi_i(hi[6]));
	misr_host_model u_host (.clk_i, .reg_rdata_i(reg_rdata_o),
		.reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i));
	task automatic chk(input string nm, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic upd(input logic [6:0] m);
		@(posedge clk_i);
		reading_update_i <= m;
		@(posedge clk_i);
		reading_update_i <= 7'h00;
		#1;
	endtask : upd
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic t_set;
		@(posedge clk_i);
		{volt_enable_i, temp_enable_i, start_monitor_i} <= {16'h0f0e, 1'b1};
		{rv[0], rv[1], rv[2]} <= {8'h10, 8'h80, 8'h00};
		{rv[4], rv[5], rv[6]} <= {8'h81, 8'h81, 8'h10};
		upd(7'h7f);
		chk("limits", status_o, 8'h75);
		@(posedge clk_i);
		foreach (rv[i]) rv[i] <= 8'h40;
		upd(7'h7f);
		chk("sticky", status_o, 8'h75);
		u_host.cyc(1'b1, A, 8'hff, q);
		chk("write", status_o, 8'h75);
		u_host.cyc(1'b0, A, 8'h00, q);
		chk("rdata", q, 8'h75);
		chk("clear", status_o, 8'h00);
		@(posedge clk_i);
		rv[2] <= 8'h00;
		fork
			upd(7'h04);
			u_host.cyc(1'b0, A, 8'h00, q);
		join
		chk("rd event q", q, 8'h00);
		chk("rd event", status_o, 8'h04);
		@(posedge clk_i);
		rv[2] <= 8'h40;
		u_host.cyc(1'b0, A, 8'h00, q);
		chk("rd clear q", q, 8'h04);
		chk("rd clear", status_o, 8'h00);
		$display("t_set done");
	endtask : t_set
	task automatic t_dis;
		@(posedge clk_i);
		{volt_enable_i, rv[3]} <= 16'h0000;
		upd(7'h08);
		chk("masked", status_o, 8'h00);
		@(posedge clk_i);
		volt_enable_i <= 8'h08;
		upd(7'h08);
		chk("enabled", status_o, 8'h08);
		u_host.cyc(1'b0, A, 8'h00, q);
		chk("held rd", q, 8'h08);
		chk("held", status_o, 8'h08);
		@(posedge clk_i);
		{volt_enable_i, start_monitor_i} <= 9'h000;
		upd(7'h08);
		chk("stopped", status_o, 8'h08);
		@(posedge clk_i);
		start_monitor_i <= 1'b1;
		upd(7'h08);
		chk("release", status_o, 8'h00);
		$display("t_dis done");
	endtask : t_dis
	task automatic t_sum;
		@(posedge clk_i);
		{second_status_summary_i, start_monitor_i} <= 2'b10;
		repeat (4) @(posedge clk_i);
		#1 chk("sum on", status_o, 8'h80);
		u_host.cyc(1'b0, A, 8'h00, q);
		chk("sum read", q, 8'h80);
		@(posedge clk_i);
		second_status_summary_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 chk("sum off", status_o, 8'h00);
		$display("t_sum done");
	endtask : t_sum
	initial begin
		foreach (rv[i]) {rv[i], lo[i], hi[i]} = 24'h401080;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		#1 chk("reset", status_o, 8'h00);
		t_set();
		t_dis();
		t_sum();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		close_out();
	end
endmodule : tb
